// [cbr_pkg.sv]
package cbr_pkg;

  // reset vector bytes: low byte at the even address, high at the odd one
  localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR = 16'h0001;

  // data space windows
  localparam logic [7:0]  PERIPH_PAGE = 8'hFF;
  localparam logic [15:0] GPR_BASE    = 16'hFEE0;

  // flag word layout and reset value
  localparam int          PSW_CY   = 0;
  localparam int          PSW_ISP  = 1;
  localparam int          PSW_BANK_SEL_LOW = 3;
  localparam int          PSW_AC   = 4;
  localparam int          PSW_BANK_SEL_HIGH = 5;
  localparam int          PSW_Z    = 6;
  localparam int          PSW_IE   = 7;
  localparam logic [7:0]  PSW_RESET = 8'h02;

  // register map on the ahb-lite slave, byte offsets
  localparam logic [11:0] OFS_PC     = 12'h000;
  localparam logic [11:0] OFS_FLAGS  = 12'h004;
  localparam logic [11:0] OFS_SP     = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_GPR    = 12'h100;

  // register indices inside a bank
  localparam logic [2:0]  REG_X = 3'h0;
  localparam logic [2:0]  REG_A = 3'h1;

  localparam int          NUM_SRC = 8;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_ADVANCE, CMD_BRANCH, CMD_BRANCH_PAIR,
    CMD_PUSH_FLAGS, CMD_POP_FLAGS, CMD_IRQ_RET, CMD_BRK_RET,
    CMD_MASK_ALL, CMD_UNMASK_ALL, CMD_SEL_BANK, CMD_LOAD_SP
  } cbr_cmd_type;

  typedef enum logic [2:0] {
    ALU_NONE, ALU_ADD, ALU_SUB, ALU_ROL, ALU_ROR, ALU_BIT
  } cbr_alu_op_type;

  typedef enum logic [2:0] {
    ST_VEC_LO, ST_VEC_HI, ST_GET_LO, ST_GET_HI,
    ST_IDLE, ST_POP_WAIT, ST_POP_GET
  } cbr_state_type;

  typedef struct packed {
    cbr_cmd_type cmd;
    logic [15:0] arg;
  } cbr_exec_type;

  typedef struct packed {
    cbr_alu_op_type op;
    logic [7:0]     a;
    logic [7:0]     b;
    logic           bit_val;
  } cbr_alu_type;

  typedef struct packed {
    logic        en;
    logic        pair;
    logic [2:0]  idx;
    logic [15:0] data;
  } cbr_gpr_wr_type;

endpackage : cbr_pkg

// [cbr_core_regs.sv]
`timescale 1ns/10ps
// Overview of operation
// [RULE1] Peripheral registers live only in data addresses FF00H to FFFFH.
// [RULE2] Software never touches unassigned addresses in the peripheral window.
// [RULE3] Fetch address is 16 bits and steps by each fetched instruction length.
// [RULE4] A branch loads the fetch address from an immediate or a register.
// [RULE5] Reset loads the fetch address from vector bytes at 0000H and 0001H.
// [RULE6] Vector low byte comes from the even address, high byte from odd.
// [RULE7] The flag word resets to 02H.
// [RULE8] Flag word pushed on acknowledge or push; restored by returns or pop.
// [RULE9] With master accept clear only non-maskable requests are acknowledged.
// [RULE10] With master accept set, service level, masks and priorities decide.
// [RULE11] Mask-all or acknowledge clears master accept; unmask-all sets it.
// [RULE12] Result-null flag is set for a zero result, cleared otherwise.
// [RULE13] Two bank select bits pick one of four banks, set by bank switch.
// [RULE14] Half-carry flag follows carry out of or borrow into bit 3.
// [RULE15] Service level flag 0 blocks low priority maskable requests.
// [RULE16] Carry takes add/sub overflow, rotate shift-out and bit results.
// [RULE17] Software keeps the stack pointer within FB00H to FEFFH.
// [RULE18] Stack pointer decrements before a save, increments after a restore.
// [RULE19] Reset leaves the stack pointer undefined; software loads it first.
// [RULE20] Four banks of eight byte registers occupy FEE0H to FEFFH.
// [RULE21] Bank registers work alone as bytes or as four 16-bit pairs.
// [RULE22] Indices 0..7 are X,A,C,B,E,D,L,H; pairs 0..3 are AX,BC,DE,HL.
module cbr_core_regs (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // ahb-lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  // execution unit requests
  input  wire cbr_pkg::cbr_exec_type    exec_req,
  input  wire cbr_pkg::cbr_alu_type     alu_req,
  input  wire cbr_pkg::cbr_gpr_wr_type  gpr_wr,
  input  wire logic [2:0]               rd_idx,
  input  wire logic [1:0]               rd_pair,
  output logic [7:0]                    rd_byte,
  output logic [15:0]                   rd_pair_val,
  output logic                          busy,
  output logic [15:0]                   next_fetch_addr,
  output logic [7:0]                    flag_word,
  // interrupt requests
  input  wire logic                     irq_nmi,
  input  wire logic [7:0]               irq_req,
  input  wire logic [7:0]               irq_mask,
  input  wire logic [7:0]               irq_prio_low,
  output logic                          irq_ack,
  output logic                          irq_ack_nmi,
  output logic [2:0]                    irq_src,
  // stack and vector memory
  output logic                          mem_re,
  output logic                          mem_we,
  output logic [15:0]                   mem_addr,
  output logic [7:0]                    mem_wdata,
  input  wire logic [7:0]               mem_rdata,
  // data space port
  input  wire logic [15:0]              d_addr,
  input  wire logic                     d_we,
  input  wire logic [7:0]               d_wdata,
  output logic [7:0]                    d_rdata,
  output logic                          periph_sel,
  output logic                          gpr_hit
);

  cbr_pkg::cbr_state_type state_ff, nxt_state;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0]  flags_ff, nxt_flags;
  logic [15:0] sp_ff, nxt_sp;
  logic [7:0]  vec_lo_ff, nxt_vec_lo;
  logic        mem_re_ff, nxt_mem_re;
  logic        mem_we_ff, nxt_mem_we;
  logic [15:0] mem_addr_ff, nxt_mem_addr;
  logic [7:0]  mem_wdata_ff, nxt_mem_wdata;
  logic        ack_ff, nxt_ack;
  logic        ack_nmi_ff;
  logic [2:0]  src_ff;
  logic        ahb_wr_ff;
  logic [11:0] ahb_addr_ff;
  logic [31:0] hrdata_ff;
  logic [7:0]  rd_byte_ff, d_rdata_ff;
  logic [15:0] rd_pair_ff;
  logic [7:0]  gpr_mem [0:31];

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // decode
  wire idle   = state_ff == cbr_pkg::ST_IDLE;
  wire ie     = flags_ff[cbr_pkg::PSW_IE];
  wire serviced_level_flag    = flags_ff[cbr_pkg::PSW_ISP];
  wire [1:0] bank = {flags_ff[cbr_pkg::PSW_BANK_SEL_HIGH], flags_ff[cbr_pkg::PSW_BANK_SEL_LOW]}; // RULE13
  wire [15:0] sp_dec = sp_ff - 16'h0001;
  wire [15:0] sp_inc = sp_ff + 16'h0001;

  // pair p is {register 2p+1, register 2p}: A:X, B:C, D:E, H:L
  wire [4:0]  br_lo   = {bank, exec_req.arg[1:0], 1'b0}; // RULE22
  wire [15:0] br_pair = {gpr_mem[br_lo | 5'h01], gpr_mem[br_lo]}; // RULE21

  // interrupt eligibility, one slice per source
  logic [7:0] src_ok;
  for (genvar s = 0; s < cbr_pkg::NUM_SRC; s++) begin : g_src
    assign src_ok[s] = irq_req[s] & ~irq_mask[s] & (~irq_prio_low[s] | serviced_level_flag); // RULE10 RULE15
  end

  function automatic logic [2:0] first_src(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) idx = 3'(i);
    end
    return idx;
  endfunction : first_src

  // maskable requests only pass while the master accept flag is set
  wire mask_ok  = ie & (|src_ok); // RULE9
  wire take_irq = idle & (exec_req.cmd == cbr_pkg::CMD_NONE) & (irq_nmi | mask_ok);

  // flag arithmetic
  wire [8:0] add9   = {1'b0, alu_req.a} + {1'b0, alu_req.b};
  wire [8:0] sub9   = {1'b0, alu_req.a} - {1'b0, alu_req.b};
  wire [4:0] add_lo = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]};
  wire       sub_hb = alu_req.a[3:0] < alu_req.b[3:0];

  // ahb-lite: zero wait states, always OKAY
  wire ahb_go       = hsel & htrans[1] & hready;
  wire ahb_pc_we    = ahb_wr_ff & (ahb_addr_ff == cbr_pkg::OFS_PC);
  wire ahb_flags_we = ahb_wr_ff & (ahb_addr_ff == cbr_pkg::OFS_FLAGS);
  wire ahb_sp_we    = ahb_wr_ff & (ahb_addr_ff == cbr_pkg::OFS_SP);
  wire ahb_gpr_we   = ahb_wr_ff & (ahb_addr_ff[11:7] == cbr_pkg::OFS_GPR[11:7]);
  wire [11:0] ra    = haddr[11:0];
  wire ra_gpr       = ra[11:7] == cbr_pkg::OFS_GPR[11:7];
  wire [31:0] ahb_rd_val =
    (ra == cbr_pkg::OFS_PC)     ? {16'h0000, pc_ff} :
    (ra == cbr_pkg::OFS_FLAGS)  ? {24'h00_0000, flags_ff} :
    (ra == cbr_pkg::OFS_SP)     ? {16'h0000, sp_ff} :
    (ra == cbr_pkg::OFS_STATUS) ? {29'h0000_0000, bank, ~idle} :
    (ra_gpr && ra[1:0] == 2'h0) ? {24'h00_0000, gpr_mem[ra[6:2]]} :
                                  32'h0000_0000;

  // data space windows
  assign periph_sel = d_addr[15:8] == cbr_pkg::PERIPH_PAGE; // RULE1
  assign gpr_hit    = d_addr[15:5] == cbr_pkg::GPR_BASE[15:5]; // RULE20

  // next state
  always_comb begin
    nxt_state     = state_ff;
    nxt_pc        = pc_ff;
    nxt_flags     = flags_ff;
    nxt_sp        = sp_ff;
    nxt_vec_lo    = vec_lo_ff;
    nxt_mem_re    = 1'b0;
    nxt_mem_we    = 1'b0;
    nxt_mem_addr  = mem_addr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_ack       = 1'b0;
    case (state_ff)
      cbr_pkg::ST_VEC_LO: begin
        nxt_mem_re   = 1'b1;
        nxt_mem_addr = cbr_pkg::VEC_LO_ADDR; // RULE5
        nxt_state    = cbr_pkg::ST_VEC_HI;
      end
      cbr_pkg::ST_VEC_HI: begin
        nxt_mem_re   = 1'b1;
        nxt_mem_addr = cbr_pkg::VEC_HI_ADDR; // RULE6
        nxt_state    = cbr_pkg::ST_GET_LO;
      end
      cbr_pkg::ST_GET_LO: begin
        nxt_vec_lo = mem_rdata;
        nxt_state  = cbr_pkg::ST_GET_HI;
      end
      cbr_pkg::ST_GET_HI: begin
        nxt_pc    = {mem_rdata, vec_lo_ff}; // RULE5 RULE6
        nxt_state = cbr_pkg::ST_IDLE;
      end
      cbr_pkg::ST_POP_WAIT: nxt_state = cbr_pkg::ST_POP_GET;
      cbr_pkg::ST_POP_GET: begin
        nxt_flags = mem_rdata; // RULE8
        nxt_sp    = sp_inc; // RULE18
        nxt_state = cbr_pkg::ST_IDLE;
      end
      cbr_pkg::ST_IDLE: begin
        if (take_irq) begin
          nxt_sp        = sp_dec; // RULE18
          nxt_mem_we    = 1'b1;
          nxt_mem_addr  = sp_dec;
          nxt_mem_wdata = flags_ff; // RULE8
          nxt_flags[cbr_pkg::PSW_IE] = 1'b0; // RULE11
          nxt_ack       = 1'b1;
        end else begin
          case (exec_req.cmd)
            cbr_pkg::CMD_ADVANCE: nxt_pc = pc_ff + {13'h0000, exec_req.arg[2:0]}; // RULE3
            cbr_pkg::CMD_BRANCH: nxt_pc = exec_req.arg; // RULE4
            cbr_pkg::CMD_BRANCH_PAIR: nxt_pc = br_pair; // RULE4
            cbr_pkg::CMD_PUSH_FLAGS: begin
              nxt_sp        = sp_dec; // RULE18
              nxt_mem_we    = 1'b1;
              nxt_mem_addr  = sp_dec;
              nxt_mem_wdata = flags_ff; // RULE8
            end
            cbr_pkg::CMD_POP_FLAGS,
            cbr_pkg::CMD_IRQ_RET,
            cbr_pkg::CMD_BRK_RET: begin
              nxt_mem_re   = 1'b1;
              nxt_mem_addr = sp_ff; // RULE8
              nxt_state    = cbr_pkg::ST_POP_WAIT;
            end
            cbr_pkg::CMD_MASK_ALL: nxt_flags[cbr_pkg::PSW_IE] = 1'b0; // RULE11
            cbr_pkg::CMD_UNMASK_ALL: nxt_flags[cbr_pkg::PSW_IE] = 1'b1; // RULE11
            cbr_pkg::CMD_SEL_BANK: begin
              nxt_flags[cbr_pkg::PSW_BANK_SEL_LOW] = exec_req.arg[0]; // RULE13
              nxt_flags[cbr_pkg::PSW_BANK_SEL_HIGH] = exec_req.arg[1];
            end
            cbr_pkg::CMD_LOAD_SP: nxt_sp = exec_req.arg;
            default: ;
          endcase
        end
      end
      default: begin
        nxt_state = cbr_pkg::ST_IDLE;
      end
    endcase
    // alu flag updates land after a pop, so the newer result wins
    case (alu_req.op)
      cbr_pkg::ALU_ADD: begin
        nxt_flags[cbr_pkg::PSW_Z]  = add9[7:0] == 8'h00; // RULE12
        nxt_flags[cbr_pkg::PSW_AC] = add_lo[4]; // RULE14
        nxt_flags[cbr_pkg::PSW_CY] = add9[8]; // RULE16
      end
      cbr_pkg::ALU_SUB: begin
        nxt_flags[cbr_pkg::PSW_Z]  = sub9[7:0] == 8'h00; // RULE12
        nxt_flags[cbr_pkg::PSW_AC] = sub_hb; // RULE14
        nxt_flags[cbr_pkg::PSW_CY] = sub9[8]; // RULE16
      end
      cbr_pkg::ALU_ROL: nxt_flags[cbr_pkg::PSW_CY] = alu_req.a[7]; // RULE16
      cbr_pkg::ALU_ROR: nxt_flags[cbr_pkg::PSW_CY] = alu_req.a[0]; // RULE16
      cbr_pkg::ALU_BIT: nxt_flags[cbr_pkg::PSW_CY] = alu_req.bit_val; // RULE16
      default: ;
    endcase
    // bus writes win over the core in the same cycle
    if (ahb_pc_we) nxt_pc = hwdata[15:0];
    if (ahb_flags_we) nxt_flags = hwdata[7:0];
    if (ahb_sp_we) nxt_sp = hwdata[15:0];
  end

  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff   <= cbr_pkg::ST_VEC_LO;
      pc_ff      <= 16'h0000;
      flags_ff   <= cbr_pkg::PSW_RESET; // RULE7
      vec_lo_ff  <= 8'h00;
      mem_re_ff  <= 1'b0;
      mem_we_ff  <= 1'b0;
      mem_addr_ff  <= 16'h0000;
      mem_wdata_ff <= 8'h00;
      ack_ff     <= 1'b0;
      ack_nmi_ff <= 1'b0;
      src_ff     <= 3'h0;
    end else begin
      state_ff   <= nxt_state;
      pc_ff      <= nxt_pc;
      flags_ff   <= nxt_flags;
      vec_lo_ff  <= nxt_vec_lo;
      mem_re_ff  <= nxt_mem_re;
      mem_we_ff  <= nxt_mem_we;
      mem_addr_ff  <= nxt_mem_addr;
      mem_wdata_ff <= nxt_mem_wdata;
      ack_ff     <= nxt_ack;
      ack_nmi_ff <= nxt_ack & irq_nmi;
      src_ff     <= nxt_ack ? first_src(src_ok) : src_ff;
    end
  end

  // no reset: the stack pointer stays undefined until software loads it
  always_ff @(posedge clk) sp_ff <= nxt_sp; // RULE19

  always_ff @(posedge clk) begin
    if (reset) begin
      ahb_wr_ff   <= 1'b0;
      ahb_addr_ff <= 12'h000;
      hrdata_ff   <= 32'h0000_0000;
    end else begin
      ahb_wr_ff <= ahb_go & hwrite;
      if (ahb_go) ahb_addr_ff <= ra;
      if (ahb_go && !hwrite) hrdata_ff <= ahb_rd_val;
    end
  end

  // register banks: index is {bank, register}, byte address FEE0H + index
  always_ff @(posedge clk) begin
    if (gpr_wr.en && gpr_wr.pair) begin
      gpr_mem[{bank, gpr_wr.idx[1:0], 1'b0}] <= gpr_wr.data[7:0]; // RULE21
      gpr_mem[{bank, gpr_wr.idx[1:0], 1'b1}] <= gpr_wr.data[15:8];
    end else if (gpr_wr.en) begin
      gpr_mem[{bank, gpr_wr.idx}] <= gpr_wr.data[7:0]; // RULE21
    end
    if (d_we && gpr_hit) begin
      gpr_mem[d_addr[4:0]] <= d_wdata; // RULE20
    end
    if (ahb_gpr_we) begin
      gpr_mem[ahb_addr_ff[6:2]] <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_byte_ff <= 8'h00;
      rd_pair_ff <= 16'h0000;
      d_rdata_ff <= 8'h00;
    end else begin
      rd_byte_ff <= gpr_mem[{bank, rd_idx}];
      rd_pair_ff <= {gpr_mem[{bank, rd_pair, 1'b1}], gpr_mem[{bank, rd_pair, 1'b0}]}; // RULE22
      d_rdata_ff <= gpr_hit ? gpr_mem[d_addr[4:0]] : 8'h00;
    end
  end

  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = hrdata_ff;
  assign rd_byte         = rd_byte_ff;
  assign rd_pair_val     = rd_pair_ff;
  assign busy            = ~idle;
  assign next_fetch_addr = pc_ff;
  assign flag_word       = flags_ff;
  assign irq_ack         = ack_ff;
  assign irq_ack_nmi     = ack_nmi_ff;
  assign irq_src         = src_ff;
  assign mem_re          = mem_re_ff;
  assign mem_we          = mem_we_ff;
  assign mem_addr        = mem_addr_ff;
  assign mem_wdata       = mem_wdata_ff;
  assign d_rdata         = d_rdata_ff;

  // checks
  a_flags_reset_val: // RULE7
    assert property ($fell(reset) |-> flags_ff == cbr_pkg::PSW_RESET)
    else $error("flag word not 02H after reset");
  a_vector_read_order: // RULE5
    assert property ($fell(reset) |-> ##1 (mem_re_ff && mem_addr_ff == cbr_pkg::VEC_LO_ADDR)
                     ##1 (mem_re_ff && mem_addr_ff == cbr_pkg::VEC_HI_ADDR))
    else $error("reset vector bytes not read in order");
  a_vector_byte_join: // RULE6
    assert property ((state_ff == cbr_pkg::ST_GET_HI && !ahb_pc_we)
                     |=> pc_ff == {$past(mem_rdata), $past(vec_lo_ff)})
    else $error("vector bytes joined wrongly");
  a_pc_advance_len: // RULE3
    assert property ((idle && exec_req.cmd == cbr_pkg::CMD_ADVANCE && !ahb_pc_we)
                     |=> pc_ff == $past(pc_ff) + {13'h0000, $past(exec_req.arg[2:0])})
    else $error("fetch address did not step by length");
  a_branch_target: // RULE4
    assert property ((idle && exec_req.cmd == cbr_pkg::CMD_BRANCH && !ahb_pc_we)
                     |=> pc_ff == $past(exec_req.arg))
    else $error("branch target not loaded");
  a_zero_flag_add: // RULE12
    assert property ((alu_req.op == cbr_pkg::ALU_ADD && !ahb_flags_we)
                     |=> flags_ff[cbr_pkg::PSW_Z] == ($past(add9[7:0]) == 8'h00))
    else $error("zero flag wrong after add");
  a_half_borrow_sub: // RULE14
    assert property ((alu_req.op == cbr_pkg::ALU_SUB && !ahb_flags_we)
                     |=> flags_ff[cbr_pkg::PSW_AC] == $past(alu_req.a[3:0] < alu_req.b[3:0]))
    else $error("half-carry wrong after subtract");
  a_mask_blocks_irq: // RULE9
    assert property ((irq_ack && !irq_ack_nmi) |-> $past(flags_ff[cbr_pkg::PSW_IE]))
    else $error("maskable request taken while masked");
  a_low_prio_block: // RULE15
    assert property ((irq_ack && !irq_ack_nmi)
                     |-> ($past(flags_ff[cbr_pkg::PSW_ISP])
                          || ($past(irq_prio_low) & (8'h01 << irq_src)) == 8'h00))
    else $error("low priority taken at service level 0");
  a_ack_clears_ie: // RULE11
    assert property ((irq_ack && !$past(ahb_flags_we)) |-> !flags_ff[cbr_pkg::PSW_IE])
    else $error("accept flag still set after acknowledge");
  a_push_predec: // RULE18
    assert property ((idle && exec_req.cmd == cbr_pkg::CMD_PUSH_FLAGS && !ahb_sp_we)
                     |=> mem_we_ff && mem_addr_ff == $past(sp_dec) && sp_ff == mem_addr_ff
                         && mem_wdata_ff == $past(flags_ff))
    else $error("push did not decrement before write");
  a_pop_postinc: // RULE8
    assert property ((state_ff == cbr_pkg::ST_POP_GET && !ahb_sp_we && !ahb_flags_we
                      && alu_req.op == cbr_pkg::ALU_NONE)
                     |=> sp_ff == $past(sp_inc) && flags_ff == $past(mem_rdata))
    else $error("pop did not restore and increment");

endmodule : cbr_core_regs

// [cbr_core_regs_test.sv]
`timescale 1ns/10ps
module cbr_core_regs_test;
  logic                    clk = 1'b0;
  logic                    reset = 1'b1;
  logic                    hsel = 1'b0, hwrite = 1'b0, d_we = 1'b0, irq_nmi = 1'b0;
  logic [31:0]             haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [1:0]              htrans = 2'h0, rd_pair = 2'h0;
  logic [2:0]              hsize = 3'h2, rd_idx = 3'h0;
  wire                     hready;
  logic                    hreadyout, hresp, busy, irq_ack, irq_ack_nmi;
  logic                    mem_re, mem_we, periph_sel, gpr_hit;
  logic [31:0]             hrdata;
  cbr_pkg::cbr_exec_type   exec_req = '0;
  cbr_pkg::cbr_alu_type    alu_req = '0;
  cbr_pkg::cbr_gpr_wr_type gpr_wr = '0;
  logic [7:0]              rd_byte, flag_word, mem_wdata, d_rdata;
  logic [15:0]             rd_pair_val, next_fetch_addr, mem_addr;
  logic [7:0]              irq_req = 8'h00, irq_mask = 8'h00, irq_prio_low = 8'h00;
  logic [2:0]              irq_src;
  logic [7:0]              mem_rdata = 8'h00, d_wdata = 8'h00;
  logic [15:0]             d_addr = 16'h0000;
  logic [7:0]              ram [0:65535];
  int                      n_errors = 0, tests_run = 0, n_ack = 0;
  int                      seed = 32'hed6468d2;

  assign hready = hreadyout;
  always #50 clk = ~clk;

  cbr_core_regs dut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .exec_req(exec_req), .alu_req(alu_req), .gpr_wr(gpr_wr),
    .rd_idx(rd_idx), .rd_pair(rd_pair), .rd_byte(rd_byte), .rd_pair_val(rd_pair_val),
    .busy(busy), .next_fetch_addr(next_fetch_addr), .flag_word(flag_word),
    .irq_nmi(irq_nmi), .irq_req(irq_req), .irq_mask(irq_mask), .irq_prio_low(irq_prio_low),
    .irq_ack(irq_ack), .irq_ack_nmi(irq_ack_nmi), .irq_src(irq_src), .mem_re(mem_re),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .d_addr(d_addr), .d_we(d_we), .d_wdata(d_wdata), .d_rdata(d_rdata),
    .periph_sel(periph_sel), .gpr_hit(gpr_hit));

  // sync ram; between reads the data line keeps toggling so stale bytes never match
  always @(posedge clk) begin
    if (mem_we === 1'b1) ram[mem_addr] <= mem_wdata;
    mem_rdata <= (mem_re === 1'b1) ? ram[mem_addr] : ~mem_rdata;
    if (irq_ack === 1'b1) n_ack <= n_ack + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic ahb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0_0000, ofs};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic exec(input cbr_pkg::cbr_cmd_type c, input logic [15:0] a);
    @(posedge clk);
    exec_req <= '{cmd: c, arg: a};
    @(posedge clk);
    exec_req <= '{cmd: cbr_pkg::CMD_NONE, arg: 16'h0000};
    #1;
    for (int i = 0; i < 8 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : exec

  task automatic wait_ack;
    for (int i = 0; i < 10 && irq_ack !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    irq_req <= 8'h00;
    irq_nmi <= 1'b0;
  endtask : wait_ack

  task automatic gpr_put(input logic p, input logic [2:0] idx, input logic [15:0] w,
                         input logic [15:0] da);
    @(posedge clk);
    gpr_wr <= '{en: 1'b1, pair: p, idx: idx, data: w};
    rd_idx <= idx;
    rd_pair <= idx[1:0];
    d_addr <= da;
    @(posedge clk);
    gpr_wr <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : gpr_put

  // expected {zero, half carry, carry}; rotates and bit ops keep zero and half carry
  function automatic logic [2:0] alu_exp(input cbr_pkg::cbr_alu_op_type op,
                                         input logic [7:0] a, b, input logic bv,
                                         input logic [2:0] old);
    logic [8:0] s;
    logic [4:0] h;
    s = (op == cbr_pkg::ALU_SUB) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    h = (op == cbr_pkg::ALU_SUB) ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + b[3:0];
    case (op)
      cbr_pkg::ALU_ROL: return {old[2:1], a[7]};
      cbr_pkg::ALU_ROR: return {old[2:1], a[0]};
      cbr_pkg::ALU_BIT: return {old[2:1], bv};
      default:          return {s[7:0] == 8'h00, h[4], s[8]};
    endcase
  endfunction : alu_exp

  initial begin
    #5_000_000;
    n_errors++;
    close_out();
  end

  initial begin
    logic [31:0]             rd;
    logic [7:0]              v, a, b;
    logic [15:0]             pc, sp, w;
    logic [2:0]              old;
    cbr_pkg::cbr_alu_op_type op;
    cbr_pkg::cbr_cmd_type    pops [3];
    pops = '{cbr_pkg::CMD_POP_FLAGS, cbr_pkg::CMD_IRQ_RET, cbr_pkg::CMD_BRK_RET};
    pc = 16'($random(seed));
    ram[0] = pc[7:0];
    ram[1] = pc[15:8];
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1 check("flags in reset", flag_word, cbr_pkg::PSW_RESET);
    repeat (5) @(posedge clk);
    #1 check("reset vector", next_fetch_addr, pc);
    check("busy after fetch", busy, 1'b0);
    ahb(1'b1, 12'h044, 32'hffff_ffff, rd);
    ahb(1'b0, 12'h044, 32'h0000_0000, rd);
    check("unmapped read", rd, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      exec(cbr_pkg::CMD_ADVANCE, {13'h0000, v[2:0]});
      pc = pc + v[2:0];
      check("pc step", next_fetch_addr, pc);
    end
    pc = 16'($random(seed));
    exec(cbr_pkg::CMD_BRANCH, pc);
    check("pc branch", next_fetch_addr, pc);
    ahb(1'b0, cbr_pkg::OFS_PC, 32'h0000_0000, rd);
    check("pc on bus", rd, {16'h0000, pc});
    // the stack is placed in high-speed ram before any use
    sp = 16'hFE00;
    exec(cbr_pkg::CMD_LOAD_SP, sp);
    for (int i = 0; i < 3; i++) begin
      v = flag_word;
      exec(cbr_pkg::CMD_PUSH_FLAGS, 16'h0000);
      sp = sp - 1'b1;
      repeat (2) @(posedge clk);
      #1 check("pushed flags", ram[sp], v);
      ahb(1'b1, cbr_pkg::OFS_FLAGS, {24'h00_0000, v ^ 8'h39}, rd);
      exec(pops[i], 16'h0000);
      sp = sp + 1'b1;
      check("restored flags", flag_word, v);
      ahb(1'b0, cbr_pkg::OFS_SP, 32'h0000_0000, rd);
      check("sp after pop", rd, {16'h0000, sp});
    end
    exec(cbr_pkg::CMD_UNMASK_ALL, 16'h0000);
    check("unmask all", flag_word[cbr_pkg::PSW_IE], 1'b1);
    exec(cbr_pkg::CMD_MASK_ALL, 16'h0000);
    check("mask all", flag_word[cbr_pkg::PSW_IE], 1'b0);
    irq_req <= 8'h0C;
    irq_mask <= 8'h04;
    repeat (6) @(posedge clk);
    #1 check("ack while masked off", n_ack, 0);
    exec(cbr_pkg::CMD_UNMASK_ALL, 16'h0000);
    v = flag_word;
    wait_ack();
    check("source chosen", irq_src, 3'h3);
    check("nmi flag", irq_ack_nmi, 1'b0);
    repeat (2) @(posedge clk);
    #1 check("accept after ack", flag_word[cbr_pkg::PSW_IE], 1'b0);
    sp = sp - 1'b1;
    check("flags pushed on ack", ram[sp], v);
    ahb(1'b1, cbr_pkg::OFS_FLAGS, 32'h0000_0080, rd);
    irq_req <= 8'h01;
    irq_mask <= 8'h00;
    irq_prio_low <= 8'h01;
    repeat (6) @(posedge clk);
    #1 check("low level blocked", n_ack, 1);
    irq_prio_low <= 8'h00;
    wait_ack();
    check("high level taken", irq_src, 3'h0);
    sp = sp - 1'b1;
    @(posedge clk);
    #1 irq_nmi <= 1'b1;
    wait_ack();
    check("nmi with accept off", irq_ack_nmi, 1'b1);
    ahb(1'b0, cbr_pkg::OFS_SP, 32'h0000_0000, rd);
    check("sp after acks", rd, {16'h0000, sp - 16'h0001});
    for (int bk = 0; bk < 4; bk++) begin
      exec(cbr_pkg::CMD_SEL_BANK, 16'(bk));
      check("bank bits", {flag_word[cbr_pkg::PSW_BANK_SEL_HIGH], flag_word[cbr_pkg::PSW_BANK_SEL_LOW]}, bk);
      v = 8'($random(seed));
      gpr_put(1'b0, 3'(bk ^ 5), {8'h00, v}, cbr_pkg::GPR_BASE + 16'(bk * 8 + (bk ^ 5)));
      check("gpr data space", d_rdata, v);
      check("gpr byte read", rd_byte, v);
      check("gpr hit", gpr_hit, 1'b1);
      ahb(1'b0, 12'(12'h100 + 4 * (bk * 8 + (bk ^ 5))), 32'h0000_0000, rd);
      check("gpr on bus", rd, {24'h00_0000, v});
    end
    ahb(1'b0, cbr_pkg::OFS_STATUS, 32'h0000_0000, rd);
    check("status bank", rd[2:1], 2'h3);
    w = 16'($random(seed));
    gpr_put(1'b1, 3'h2, w, cbr_pkg::GPR_BASE + 16'h001D);
    check("pair read", rd_pair_val, w);
    check("pair high byte", d_rdata, w[15:8]);
    exec(cbr_pkg::CMD_BRANCH_PAIR, 16'h0002);
    check("branch to pair", next_fetch_addr, w);
    foreach (pops[i]) begin
      w = (i == 0) ? 16'hFEDF : (i == 1) ? 16'hFF00 : 16'hFFFF;
      @(posedge clk);
      d_addr <= w;
      @(posedge clk);
      #1 check("periph window", periph_sel, w[15:8] == 8'hFF);
      check("gpr window", gpr_hit, 1'b0);
    end
    for (int i = 0; i < 15; i++) begin
      op = cbr_pkg::cbr_alu_op_type'(1 + i % 5);
      a = (i == 0) ? 8'hFF : (i == 1) ? 8'h10 : (i == 5) ? 8'h0F : 8'($random(seed));
      b = (i < 2 || i == 5) ? 8'h01 : 8'($random(seed));
      v = 8'($random(seed));
      @(posedge clk);
      old = {flag_word[cbr_pkg::PSW_Z], flag_word[cbr_pkg::PSW_AC], flag_word[cbr_pkg::PSW_CY]};
      alu_req <= '{op: op, a: a, b: b, bit_val: v[0]};
      @(posedge clk);
      alu_req <= '0;
      #1 check("alu flags", {flag_word[cbr_pkg::PSW_Z], flag_word[cbr_pkg::PSW_AC],
                             flag_word[cbr_pkg::PSW_CY]}, alu_exp(op, a, b, v[0], old));
    end
    close_out();
  end
endmodule : cbr_core_regs_test
